// ==== bench/remote_party.sv ====
// remote serial party: handshake lines, characters toward us, xon/xoff reaction
`timescale 1ns/1ps
`default_nettype none
module remote_party (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_char,
    input wire logic cts_set,
    input wire logic dsr_set,
    input wire logic [3:0] ack_delay,
    // line toward the block
    output logic rx_valid,
    output logic [7:0] rx_char,
    output logic cts,
    output logic dsr,
    input wire logic send_req,
    input wire logic [7:0] send_char,
    output logic send_ack,
    output logic paused
);
    logic [3:0] wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'b0;
            rx_char <= 8'h00;
            cts <= 1'b0;
            dsr <= 1'b0;
            send_ack <= 1'b0;
            paused <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            cts <= cts_set;
            dsr <= dsr_set;
            rx_valid <= cmd_valid;
            // idle data flips so a stale character never looks valid
            rx_char <= cmd_valid ? cmd_char : ~rx_char;
            send_ack <= 1'b0;
            if (send_req && !send_ack) begin
                if (wait_cnt >= ack_delay) begin
                    send_ack <= 1'b1;
                    wait_cnt <= 4'h0;
                    if (send_char == uart_fc_pkg::XOFF_CHAR) paused <= 1'b1;
                    if (send_char == uart_fc_pkg::XON_CHAR) paused <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/uart_flow_control_bench.sv ====
// self-checking bench for the uart flow-control block
`timescale 1ns/1ps
`default_nettype none
module uart_flow_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, cts, dsr, rts, dtr, rx_valid, rx_store_valid;
    logic [7:0] rx_char, rx_store_char, send_char, cmd_char = 8'h00;
    logic rx_fifo_full = 1'b0, rx_fifo_empty = 1'b1, tx_enable, send_req, send_ack, paused;
    logic cmd_valid = 1'b0, cts_set = 1'b1, dsr_set = 1'b1;
    int failures = 0, checked = 0, stored = 0, base;
    logic [3:0] modes [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    always #50 pclk = ~pclk;
    uart_flow_control i_uart_flow_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts(cts), .dsr(dsr), .rts(rts),
        .dtr(dtr), .rx_valid(rx_valid), .rx_char(rx_char), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_empty(rx_fifo_empty), .rx_store_valid(rx_store_valid),
        .rx_store_char(rx_store_char), .tx_enable(tx_enable), .send_req(send_req),
        .send_char(send_char), .send_ack(send_ack));
    remote_party i_remote_party (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
        .cmd_char(cmd_char), .cts_set(cts_set), .dsr_set(dsr_set), .ack_delay(4'h3),
        .rx_valid(rx_valid), .rx_char(rx_char), .cts(cts), .dsr(dsr), .send_req(send_req),
        .send_char(send_char), .send_ack(send_ack), .paused(paused));
    always @(posedge pclk) if (rx_store_valid === 1'b1) stored <= stored + 1;
    task wrap_up();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are read as they stood at this edge
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            failures++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function logic pick(input int which);
        case (which)
            0: return tx_enable;
            1: return rts;
            2: return dtr;
            3: return send_req;
            default: return paused;
        endcase
    endfunction
    // bounded wait for a flag, then compare it
    task wait_sig(input int which, input logic exp);
        int n;
        n = 0;
        while (pick(which) !== exp && n < 12) begin
            @(negedge pclk);
            n++;
        end
        check(pick(which), exp);
        if (n >= 12) wrap_up();
    endtask
    task rx(input logic [7:0] c);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_char <= c;
        @(posedge pclk);
        cmd_valid <= 1'b0;
    endtask
    task tx_case(input logic [3:0] m, input logic [7:0] resume, input int exp_store);
        apb(1'b1, uart_fc_pkg::FLOW_MODE_ADDR, {28'h0, m});
        base = stored;
        rx(uart_fc_pkg::XOFF_CHAR);
        wait_sig(0, 1'b0);
        rx(resume);
        wait_sig(0, 1'b1);
        repeat (2) @(posedge pclk);
        check(stored - base, exp_store);
        if (exp_store > 0) check(rx_store_char, resume);
        $display("test tx mode %h done", m);
    endtask
    // throttle on full, release on empty, for one receive mode
    task throttle(input logic [3:0] m, input logic on, input logic [7:0] c);
        rx_fifo_full <= on;
        rx_fifo_empty <= ~on;
        if (m[1]) wait_sig(1, on);
        if (m[2]) wait_sig(2, on);
        if (m[0]) begin
            wait_sig(3, 1'b1);
            check(send_char, c);
            wait_sig(4, on);
            wait_sig(3, 1'b0);
        end
        check(rts, on & m[1]);
        check(dtr, on & m[2]);
        check(send_req, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check(tx_enable, 1'b1);
        apb(1'b0, uart_fc_pkg::MODEM_CONTROL_ADDR, 32'h0);
        check(q, 32'h00);
        apb(1'b0, uart_fc_pkg::FLOW_MODE_ADDR, 32'h0);
        check(q, 32'h00);
        apb(1'b0, uart_fc_pkg::FLOW_STATUS_ADDR, 32'h0);
        check(q, 32'h1b);
        apb(1'b0, 16'hffb0, 32'h0);
        check({q[30:0], e}, 32'h1);
        $display("test reset done");
        apb(1'b1, uart_fc_pkg::FLOW_MODE_ADDR, 32'h0f);
        apb(1'b0, uart_fc_pkg::FLOW_MODE_ADDR, 32'h0);
        check(q, 32'h0c);
        $display("test illegal pair done");
        tx_case(4'h1, uart_fc_pkg::XON_CHAR, 0);
        tx_case(4'h2, 8'h41, 1);
        tx_case(4'h5, uart_fc_pkg::XON_CHAR, 0);
        rx(uart_fc_pkg::XOFF_CHAR);
        wait_sig(0, 1'b0);
        cts_set <= 1'b0;
        // let the line loss pass the synchroniser before xon arrives
        repeat (4) @(posedge pclk);
        rx(uart_fc_pkg::XON_CHAR);
        repeat (5) @(posedge pclk);
        check(tx_enable, 1'b0);
        cts_set <= 1'b1;
        wait_sig(0, 1'b1);
        apb(1'b1, uart_fc_pkg::FLOW_MODE_ADDR, 32'h08);
        dsr_set <= 1'b0;
        wait_sig(0, 1'b0);
        dsr_set <= 1'b1;
        wait_sig(0, 1'b1);
        $display("test handshake done");
        apb(1'b1, uart_fc_pkg::MODEM_CONTROL_ADDR, 32'h30);
        apb(1'b0, uart_fc_pkg::MODEM_CONTROL_ADDR, 32'h0);
        check(q, 32'h30);
        check({rts, dtr}, 2'b11);
        apb(1'b1, uart_fc_pkg::FLOW_MODE_ADDR, 32'h35);
        apb(1'b1, uart_fc_pkg::MODEM_CONTROL_ADDR, 32'h31);
        apb(1'b0, uart_fc_pkg::MODEM_CONTROL_ADDR, 32'h0);
        check(q, 32'h30);
        apb(1'b0, uart_fc_pkg::FLOW_MODE_ADDR, 32'h0);
        check(q, 32'h00);
        apb(1'b1, uart_fc_pkg::MODEM_CONTROL_ADDR, 32'h00);
        $display("test modem control done");
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, uart_fc_pkg::FLOW_MODE_ADDR, {25'h0, modes[i][2:0], 4'h0});
            throttle(modes[i], 1'b1, uart_fc_pkg::XOFF_CHAR);
            throttle(modes[i], 1'b0, uart_fc_pkg::XON_CHAR);
            $display("test rx mode %0d done", modes[i]);
        end
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== design/fc_if.sv ====
// link between register/receive side and transmit gate
`timescale 1ns/1ps
`default_nettype none
interface fc_if;
    logic [3:0] tx_mode;
    logic cts_ok;
    logic dsr_ok;
    logic rx_valid;
    logic [7:0] rx_char;
    logic restart;
    logic xon_state;
    logic tx_enable;
    logic consumed;
    modport ctl (output tx_mode, cts_ok, dsr_ok, rx_valid, rx_char, restart,
                 input xon_state, tx_enable, consumed);
    modport gate (input tx_mode, cts_ok, dsr_ok, rx_valid, rx_char, restart,
                  output xon_state, tx_enable, consumed);
endinterface
`default_nettype wire

// ==== design/tx_flow_gate.sv ====
// transmit gate: xon/xoff state and handshake gating
`timescale 1ns/1ps
`default_nettype none
module tx_flow_gate (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control link
    fc_if.gate fc
);
    typedef struct packed {
        logic xon;
        logic tx_enable;
    } gate_s;

    gate_s st;
    gate_s next_st;
    logic sw_on;
    logic hw_ok;

    always_comb begin
        next_st = st;
        fc.consumed = 1'b0;
        sw_on = fc.tx_mode[uart_fc_pkg::FM_TX_XONXOFF_ENABLE] | fc.tx_mode[uart_fc_pkg::FM_XON_ANY_ENABLE]; // R2
        hw_ok = (~fc.tx_mode[uart_fc_pkg::FM_CTS] | fc.cts_ok)
              & (~fc.tx_mode[uart_fc_pkg::FM_DSR] | fc.dsr_ok); // R6
        if (fc.restart || !sw_on) begin
            next_st.xon = 1'b1; // R1
        end else if (fc.rx_valid) begin
            if (fc.rx_char == uart_fc_pkg::XOFF_CHAR) begin
                next_st.xon = 1'b0; // R3
                fc.consumed = 1'b1; // R12
            end else if (fc.rx_char == uart_fc_pkg::XON_CHAR) begin
                next_st.xon = 1'b1; // R3
                fc.consumed = 1'b1; // R12
            end else if (fc.tx_mode[uart_fc_pkg::FM_XON_ANY_ENABLE]) begin
                next_st.xon = 1'b1; // R4
            end
        end
        // both conditions must permit sending before the transmitter runs again; a restart needs only xon
        next_st.tx_enable = next_st.xon & (hw_ok | fc.restart); // R6
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{xon: 1'b1, tx_enable: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign fc.xon_state = st.xon;
    assign fc.tx_enable = st.tx_enable;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_xoff_pause;
        fc.rx_valid && sw_on && !fc.restart && fc.rx_char == uart_fc_pkg::XOFF_CHAR
            |=> !fc.xon_state && !fc.tx_enable;
    endproperty
    a_xoff_pause: assert property (p_xoff_pause) else $error("xoff did not pause"); // R3

    property p_any_resume;
        fc.rx_valid && fc.tx_mode[1:0] == 2'b10 && fc.rx_char != uart_fc_pkg::XOFF_CHAR
            |=> fc.xon_state;
    endproperty
    a_any_resume: assert property (p_any_resume) else $error("any char did not resume"); // R4

    property p_hw_stop;
        fc.tx_mode[uart_fc_pkg::FM_CTS] && !fc.cts_ok && !fc.restart |=> !fc.tx_enable;
    endproperty
    a_hw_stop: assert property (p_hw_stop) else $error("cts loss did not stop"); // R6

    property p_mode0_open;
        fc.tx_mode == 4'h0 |=> fc.tx_enable;
    endproperty
    a_mode0_open: assert property (p_mode0_open) else $error("mode 0 gated tx"); // R2
endmodule
`default_nettype wire

// ==== design/uart_fc_pkg.sv ====
// constants for the uart flow-control block
// Behaviour
// R1 - any reset leaves transmitter in xon state with all flow control off
// R2 - transmit field: bit3 dsr, bit2 cts, bit1 xon-any, bit0 xon/xoff; zero disables
// R3 - xon/xoff mode pauses on received xoff and resumes on received xon
// R4 - xon-any mode pauses on xoff and resumes on any received character
// R5 - writing both xon-any and xon/xoff clears both bits
// R6 - combined mode stops on handshake loss or xoff; resumes needing both
// R7 - receive field: bit6 dtr, bit5 rts, bit4 xon/xoff; modes 0 to 7
// R8 - mode 3 changes rts and sends xoff on full; restores and sends xon on empty
// R9 - mode 6 changes dtr and rts together on full, restores both on empty
// R10 - modem_control register at 0xffa4 drives modem outputs
// R11 - remote party stops on xoff or handshake loss, resumes on xon or return; the bench remote_party ignores rts and dtr and reacts only to xoff and xon
// R12 - xon and xoff used for transmit flow control never reach the receive fifo
package uart_fc_pkg;
    localparam logic [15:0] MODEM_CONTROL_ADDR = 16'hffa4;
    localparam logic [15:0] FLOW_MODE_ADDR = 16'hffa8;
    localparam logic [15:0] FLOW_STATUS_ADDR = 16'hffac;
    localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
    localparam logic [6:0] FLOW_MODE_RESET = 7'h00;
    localparam int MC_URST = 0;
    localparam int MC_DTR = 4;
    localparam int MC_RTS = 5;
    localparam int FM_TX_XONXOFF_ENABLE = 0;
    localparam int FM_XON_ANY_ENABLE = 1;
    localparam int FM_CTS = 2;
    localparam int FM_DSR = 3;
    localparam int FM_RX_XONXOFF_ENABLE = 4;
    localparam int FM_RTS = 5;
    localparam int FM_DTR = 6;
    localparam int ST_XON = 0;
    localparam int ST_TX_EN = 1;
    localparam int ST_THROTTLE = 2;
    localparam int ST_CTS = 3;
    localparam int ST_DSR = 4;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
endpackage

// ==== design/uart_flow_control.sv ====
// uart flow control: apb registers, receive throttling, transmit gating
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_flow_control (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // modem pins
    input wire logic cts,
    input wire logic dsr,
    output logic rts,
    output logic dtr,
    // receiver side
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_fifo_full,
    input wire logic rx_fifo_empty,
    output logic rx_store_valid,
    output logic [7:0] rx_store_char,
    // transmitter side
    output logic tx_enable,
    output logic send_req,
    output logic [7:0] send_char,
    input wire logic send_ack
);
    typedef struct packed {
        logic [7:0] mc;
        logic [6:0] fm;
        logic throttled;
        logic full_q;
        logic xoff_pend;
        logic xon_pend;
        logic send_req;
        logic [7:0] send_char;
        logic rts;
        logic dtr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic store_valid;
        logic [7:0] store_char;
        logic cts_s1;
        logic cts_s2;
        logic dsr_s1;
        logic dsr_s2;
    } top_s;

    top_s st;
    top_s next_st;
    fc_if fc ();

    logic setup;
    logic wr;
    logic wr_mc;
    logic wr_fm;
    logic soft_rst;
    logic became_full;
    logic [2:0] rx_mode;
    logic [6:0] fm_val;

    tx_flow_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .fc(fc)
    );

    assign setup = psel & ~penable;
    // a write lands only at the edge that sees pready with the access phase
    assign wr = psel & penable & pwrite & st.pready & pstrb[0];
    assign wr_mc = wr & (paddr == uart_fc_pkg::MODEM_CONTROL_ADDR); // R10
    assign wr_fm = wr & (paddr == uart_fc_pkg::FLOW_MODE_ADDR);
    assign soft_rst = wr_mc & pwdata[uart_fc_pkg::MC_URST]; // R1
    assign rx_mode = st.fm[6:4]; // R7
    assign became_full = rx_fifo_full & ~st.full_q;

    always_comb begin
        fm_val = pwdata[6:0];
        if (fm_val[1:0] == 2'b11) begin
            fm_val[1:0] = 2'b00; // R5
        end
    end

    assign fc.tx_mode = st.fm[3:0]; // R2
    assign fc.cts_ok = st.cts_s2;
    assign fc.dsr_ok = st.dsr_s2;
    assign fc.rx_valid = rx_valid;
    assign fc.rx_char = rx_char;
    assign fc.restart = soft_rst;

    always_comb begin
        next_st = st;
        // pins from outside pass two flops; only the second is read
        next_st.cts_s1 = cts;
        next_st.cts_s2 = st.cts_s1;
        next_st.dsr_s1 = dsr;
        next_st.dsr_s2 = st.dsr_s1;
        next_st.full_q = rx_fifo_full;

        // apb: answer one cycle after setup, read data caught at setup
        next_st.pready = setup;
        if (setup) begin
            next_st.pslverr = 1'b0;
            unique case (paddr)
                uart_fc_pkg::MODEM_CONTROL_ADDR: next_st.prdata = {24'h000000, st.mc};
                uart_fc_pkg::FLOW_MODE_ADDR: next_st.prdata = {25'h0000000, st.fm};
                uart_fc_pkg::FLOW_STATUS_ADDR: begin
                    next_st.prdata = 32'h00000000;
                    next_st.prdata[uart_fc_pkg::ST_XON] = fc.xon_state;
                    next_st.prdata[uart_fc_pkg::ST_TX_EN] = fc.tx_enable;
                    next_st.prdata[uart_fc_pkg::ST_THROTTLE] = st.throttled;
                    next_st.prdata[uart_fc_pkg::ST_CTS] = st.cts_s2;
                    next_st.prdata[uart_fc_pkg::ST_DSR] = st.dsr_s2;
                end
                default: begin
                    next_st.prdata = 32'h00000000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end else if (!psel) begin
            next_st.pslverr = 1'b0;
        end

        // the reset bit acts once and is never stored
        if (wr_mc) begin
            next_st.mc = pwdata[7:0];
            next_st.mc[uart_fc_pkg::MC_URST] = 1'b0;
        end
        if (wr_fm) begin
            next_st.fm = fm_val; // R5
        end

        // receive character path; flow characters stop here
        next_st.store_valid = rx_valid & ~fc.consumed; // R12
        if (rx_valid) begin
            next_st.store_char = rx_char;
        end

        // send engine: one request held until the transmitter takes it
        if (st.send_req && send_ack) begin
            next_st.send_req = 1'b0;
        end else if (!st.send_req && st.xoff_pend) begin
            next_st.send_req = 1'b1;
            next_st.send_char = uart_fc_pkg::XOFF_CHAR;
            next_st.xoff_pend = 1'b0;
        end else if (!st.send_req && st.xon_pend) begin
            next_st.send_req = 1'b1;
            next_st.send_char = uart_fc_pkg::XON_CHAR;
            next_st.xon_pend = 1'b0;
        end

        // throttle on the edge into full, release once drained to empty;
        // pending flags are set after the send engine clears them, so sets win
        if (rx_mode == 3'h0) begin
            next_st.throttled = 1'b0; // R7
        end else if (!st.throttled && became_full) begin
            next_st.throttled = 1'b1; // R8 R9
            if (st.fm[uart_fc_pkg::FM_RX_XONXOFF_ENABLE]) begin
                next_st.xoff_pend = 1'b1; // R8
                next_st.xon_pend = 1'b0;
            end
        end else if (st.throttled && rx_fifo_empty) begin
            next_st.throttled = 1'b0; // R8 R9
            if (st.fm[uart_fc_pkg::FM_RX_XONXOFF_ENABLE]) begin
                next_st.xon_pend = 1'b1; // R8
                next_st.xoff_pend = 1'b0;
            end
        end

        if (soft_rst) begin
            next_st.fm = uart_fc_pkg::FLOW_MODE_RESET; // R1
            next_st.throttled = 1'b0;
            next_st.xoff_pend = 1'b0;
            next_st.xon_pend = 1'b0;
            next_st.send_req = 1'b0;
        end

        // pins follow software, inverted while throttled in the selected lines
        next_st.rts = next_st.mc[uart_fc_pkg::MC_RTS]
                    ^ (next_st.fm[uart_fc_pkg::FM_RTS] & next_st.throttled); // R8 R9 R10
        next_st.dtr = next_st.mc[uart_fc_pkg::MC_DTR]
                    ^ (next_st.fm[uart_fc_pkg::FM_DTR] & next_st.throttled); // R9 R10
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.mc <= uart_fc_pkg::MODEM_CONTROL_RESET;
            st.fm <= uart_fc_pkg::FLOW_MODE_RESET; // R1
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign rts = st.rts;
    assign dtr = st.dtr;
    assign rx_store_valid = st.store_valid;
    assign rx_store_char = st.store_char;
    assign tx_enable = fc.tx_enable;
    assign send_req = st.send_req;
    assign send_char = st.send_char;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fill;
        rx_fifo_full && !st.full_q && !st.throttled && !wr;
    endsequence

    property p_illegal_pair;
        wr_fm && pwdata[1:0] == 2'b11 |=> st.fm[1:0] == 2'b00;
    endproperty
    a_illegal_pair: assert property (p_illegal_pair) else $error("illegal pair kept"); // R5

    property p_soft_reset;
        soft_rst |=> st.fm == 7'h00 && fc.xon_state && !st.throttled;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state"); // R1

    property p_mode3_full;
        rx_mode == 3'h3 && !st.send_req ##0 s_fill
            |=> st.rts != st.mc[uart_fc_pkg::MC_RTS] ##1 send_req
                && send_char == uart_fc_pkg::XOFF_CHAR;
    endproperty
    a_mode3_full: assert property (p_mode3_full) else $error("mode 3 full missed"); // R8

    property p_mode6_full;
        rx_mode == 3'h6 ##0 s_fill
            |=> st.rts != st.mc[uart_fc_pkg::MC_RTS] && st.dtr != st.mc[uart_fc_pkg::MC_DTR];
    endproperty
    a_mode6_full: assert property (p_mode6_full) else $error("mode 6 full missed"); // R9

    property p_restore;
        st.throttled && rx_fifo_empty && rx_mode != 3'h0 && !wr
            |=> rts == st.mc[uart_fc_pkg::MC_RTS] && dtr == st.mc[uart_fc_pkg::MC_DTR];
    endproperty
    a_restore: assert property (p_restore) else $error("empty did not restore"); // R8

    // judged from mode and character, not from the consume strobe it guards
    property p_consume;
        rx_valid && !soft_rst && st.fm[1:0] != 2'b00
            && (rx_char == uart_fc_pkg::XON_CHAR || rx_char == uart_fc_pkg::XOFF_CHAR)
            |=> !rx_store_valid;
    endproperty
    a_consume: assert property (p_consume) else $error("flow char stored"); // R12

    property p_mc_pins;
        wr_mc && st.fm[6:5] == 2'b00 |=> rts == $past(pwdata[uart_fc_pkg::MC_RTS]);
    endproperty
    a_mc_pins: assert property (p_mc_pins) else $error("rts not from register"); // R10
endmodule
`default_nettype wire
